// ===== shared/dmob_defs.vh
// object indices, field positions and command codes of the monitor bank
// assumes plain Verilog-2005 inclusion by bare name
`ifndef DMOB_DEFS_VH
`define DMOB_DEFS_VH
// ==========================================================
// object indices
`define DMOB_IDX_RAM_COMMIT 16'h2060
`define DMOB_IDX_NV_COMMIT 16'h2070
`define DMOB_IDX_STATUS 16'h2100
`define DMOB_IDX_FREQ 16'h2110
`define DMOB_IDX_CURR 16'h2120
`define DMOB_IDX_TORQ 16'h2130
`define DMOB_IDX_RD_RESP 16'h2140
`define DMOB_IDX_WR_RESP 16'h2150
`define DMOB_IDX_SPEED 16'h2200
`define DMOB_IDX_DOUT 16'h60FD
`define DMOB_IDX_PROFILE_LO 16'h6000
`define DMOB_IDX_PROFILE_HI 16'h6FFF
// ==========================================================
// command word and settings
`define DMOB_SAVE_WORD 32'h65766173
`define DMOB_DISPLAY_PROFILE 4'h2
`define DMOB_ENTRY_COUNT 32'h00000001
// ==========================================================
// digital-output object bit positions
`define DMOB_DOUT_CONTACT 16
`define DMOB_DOUT_OPTO1 17
`define DMOB_DOUT_OPTO2 18
`define DMOB_DOUT_FAULT 23
// ==========================================================
// drive status word bit positions
`define DMOB_STAT_RUN 0
`define DMOB_STAT_ZERO_SPEED 1
`define DMOB_STAT_REVERSE 2
`define DMOB_STAT_FAULT_RESET 3
`define DMOB_STAT_AGREE 4
`define DMOB_STAT_READY 5
`define DMOB_STAT_ALARM 6
`define DMOB_STAT_FAULT 7
`define DMOB_STAT_OP_ERROR 8
`define DMOB_STAT_POWER_LOSS 9
`define DMOB_STAT_NET_SOURCE 10
`define DMOB_STAT_FAULT_RELAY 11
`define DMOB_STAT_OPTO1 12
`define DMOB_STAT_OPTO2 13
`define DMOB_STAT_MOTOR2 14
`define DMOB_STAT_ZERO_SERVO 15
// ==========================================================
// access answer codes
`define DMOB_ACK_OK 2'h0
`define DMOB_ACK_READ_ONLY 2'h1
`define DMOB_ACK_NO_OBJECT 2'h2
`define DMOB_ACK_NO_ACCESS 2'h3
`endif

// ===== design/dmob_resp_store.v
// response store: address+data words from the drive, one per response object
// assumes writes come from the drive side on the same clock
`timescale 1ns/1ps
module dmob_resp_store #(
   parameter WIDTH = 32,
   parameter DEPTH = 2,
   parameter AW = 1
) (
   input wire clock_i,
   input wire reset_i,
   input wire wr_en_i,
   input wire [AW-1:0] wr_addr_i,
   input wire [WIDTH-1:0] wr_data_i,
   input wire [AW-1:0] rd_addr_i,
   output reg [WIDTH-1:0] rd_data_o
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   integer i;
   // ==========================================================
   // storage with registered read port
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_q[i] <= {WIDTH{1'b0}};
         end
         rd_data_o <= {WIDTH{1'b0}};
      end else begin
         if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
         end
         rd_data_o <= mem_q[rd_addr_i];
      end
   end
endmodule // dmob_resp_store

// ===== design/dmob_object_bank.v
// object-dictionary bank: commit commands, drive monitors, register replies
// assumes the network stack and the drive core share clock_i
`timescale 1ns/1ps
`include "dmob_defs.vh"

module dmob_object_bank (
   input wire clock_i,
   input wire reset_i,
   // object access from the network stack
   input wire obj_req_i,
   input wire obj_write_i,
   input wire [15:0] obj_index_i,
   input wire [7:0] obj_subindex_i,
   input wire [31:0] obj_wdata_i,
   output reg obj_ack_o,
   output reg [1:0] obj_status_o,
   output reg [31:0] obj_rdata_o,
   // commit pulses to the drive core
   output reg ram_commit_o,
   output reg nv_commit_o,
   // drive monitors
   input wire drive_running_i,
   input wire zero_speed_i,
   input wire reverse_i,
   input wire fault_reset_input_i,
   input wire speed_agree_i,
   input wire drive_ready_i,
   input wire alarm_i,
   input wire fault_i,
   input wire operation_error_i,
   input wire power_loss_i,
   input wire network_command_source_i,
   input wire fault_relay_terminals_i,
   input wire optocoupler_output_one_i,
   input wire optocoupler_output_two_i,
   input wire relay_contact_output_i,
   input wire motor2_selected_i,
   input wire zero_servo_done_i,
   input wire [15:0] output_frequency_i,
   input wire [15:0] output_current_i,
   input wire [15:0] torque_reference_monitor_item_i,
   input wire torque_monitor_valid_i,
   input wire [15:0] speed_monitor_item_i,
   input wire speed_monitor_valid_i,
   input wire [3:0] display_unit_setting_i,
   // register replies from the drive
   input wire reply_valid_i,
   input wire reply_is_write_i,
   input wire [31:0] reply_word_i
);
   // ==========================================================
   // monitor snapshot: captured every cycle, data served from flops
   reg [15:0] status_q;
   reg [15:0] freq_q;
   reg [15:0] curr_q;
   reg [15:0] torq_q;
   reg [15:0] speed_q;
   reg [31:0] dout_q;
   reg [3:0] disp_q;
   reg [15:0] status_d;
   reg [31:0] dout_d;
   reg [15:0] torq_d;
   reg [15:0] speed_d;
   // snapshot lags the drive by one cycle; fine for slow monitors

   always @* begin
      status_d = 16'h0000;
      status_d[`DMOB_STAT_RUN] = drive_running_i;
      status_d[`DMOB_STAT_ZERO_SPEED] = zero_speed_i;
      status_d[`DMOB_STAT_REVERSE] = reverse_i;
      status_d[`DMOB_STAT_FAULT_RESET] = fault_reset_input_i;
      status_d[`DMOB_STAT_AGREE] = speed_agree_i;
      status_d[`DMOB_STAT_READY] = drive_ready_i;
      status_d[`DMOB_STAT_ALARM] = alarm_i;
      status_d[`DMOB_STAT_FAULT] = fault_i;
      status_d[`DMOB_STAT_OP_ERROR] = operation_error_i;
      status_d[`DMOB_STAT_POWER_LOSS] = power_loss_i;
      status_d[`DMOB_STAT_NET_SOURCE] = network_command_source_i;
      status_d[`DMOB_STAT_FAULT_RELAY] = fault_relay_terminals_i;
      status_d[`DMOB_STAT_OPTO1] = optocoupler_output_one_i;
      status_d[`DMOB_STAT_OPTO2] = optocoupler_output_two_i;
      status_d[`DMOB_STAT_MOTOR2] = motor2_selected_i;
      status_d[`DMOB_STAT_ZERO_SERVO] = zero_servo_done_i;
      // only four outputs are mirrored; every other bit reads zero
      dout_d = 32'h00000000;
      dout_d[`DMOB_DOUT_CONTACT] = relay_contact_output_i;
      dout_d[`DMOB_DOUT_OPTO1] = optocoupler_output_one_i;
      dout_d[`DMOB_DOUT_OPTO2] = optocoupler_output_two_i;
      dout_d[`DMOB_DOUT_FAULT] = fault_relay_terminals_i;
   end

   // a control mode without the monitor reads zero, not stale data
   always @* begin
      torq_d = 16'h0000;
      speed_d = 16'h0000;
      if (torque_monitor_valid_i) begin
         torq_d = torque_reference_monitor_item_i;
      end
      if (speed_monitor_valid_i) begin
         speed_d = speed_monitor_item_i;
      end
   end

   // monitor inputs come from drive logic on this clock: no synchroniser
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         status_q <= 16'h0000;
         freq_q <= 16'h0000;
         curr_q <= 16'h0000;
         torq_q <= 16'h0000;
         speed_q <= 16'h0000;
         dout_q <= 32'h00000000;
         disp_q <= 4'h0;
      end else begin
         status_q <= status_d;
         freq_q <= output_frequency_i;
         curr_q <= output_current_i;
         torq_q <= torq_d;
         speed_q <= speed_d;
         dout_q <= dout_d;
         disp_q <= display_unit_setting_i;
      end
   end

   // ==========================================================
   // response store, slot 0 read reply, slot 1 write reply
   wire [31:0] resp_rdata;
   wire resp_sel;
   assign resp_sel = (obj_index_i == `DMOB_IDX_WR_RESP);
   // a reply written on the taking edge shows on the next read only

   dmob_resp_store #(
      .WIDTH(32),
      .DEPTH(2),
      .AW(1)
   ) u_store (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .wr_en_i(reply_valid_i),
      .wr_addr_i(reply_is_write_i),
      .wr_data_i(reply_word_i),
      .rd_addr_i(resp_sel),
      .rd_data_o(resp_rdata)
   );

   // ==========================================================
   // access decode
   reg known;
   reg writable;
   reg profile;
   reg from_store;
   reg [31:0] rd_d;

   always @* begin
      known = 1'b1;
      writable = 1'b0;
      from_store = 1'b0;
      rd_d = 32'h00000000;
      profile = (obj_index_i >= `DMOB_IDX_PROFILE_LO) &&
         (obj_index_i <= `DMOB_IDX_PROFILE_HI);
      case (obj_index_i)
         `DMOB_IDX_RAM_COMMIT,
         `DMOB_IDX_NV_COMMIT: begin
            writable = 1'b1;
         end
         `DMOB_IDX_STATUS: rd_d = {16'h0000, status_q};
         `DMOB_IDX_FREQ: rd_d = {16'h0000, freq_q};
         `DMOB_IDX_CURR: rd_d = {16'h0000, curr_q};
         `DMOB_IDX_TORQ: rd_d = {16'h0000, torq_q};
         `DMOB_IDX_SPEED: rd_d = {16'h0000, speed_q};
         `DMOB_IDX_RD_RESP,
         `DMOB_IDX_WR_RESP: begin
            if (obj_subindex_i == 8'h00) begin
               rd_d = `DMOB_ENTRY_COUNT;
            end else begin
               from_store = 1'b1;
            end
         end
         `DMOB_IDX_DOUT: rd_d = dout_q;
         default: known = 1'b0;
      endcase
   end

   // ==========================================================
   // answer classification and commit decode
   reg [1:0] code_d;
   reg ram_hit;
   reg nv_hit;

   // refusal order: profile gate first, then unknown, then read-only
   always @* begin
      code_d = `DMOB_ACK_OK;
      if (profile && disp_q != `DMOB_DISPLAY_PROFILE) begin
         code_d = `DMOB_ACK_NO_ACCESS;
      end else if (!known) begin
         code_d = `DMOB_ACK_NO_OBJECT;
      end else if (obj_write_i && !writable) begin
         code_d = `DMOB_ACK_READ_ONLY;
      end
   end

   // only the exact SAVE word counts; the drive core tracks every
   // changed parameter itself, so one pulse activates all of them
   always @* begin
      ram_hit = 1'b0;
      nv_hit = 1'b0;
      if (obj_write_i && obj_wdata_i == `DMOB_SAVE_WORD) begin
         case (obj_index_i)
            `DMOB_IDX_RAM_COMMIT: ram_hit = 1'b1;
            `DMOB_IDX_NV_COMMIT: nv_hit = 1'b1;
            default: begin
               ram_hit = 1'b0;
               nv_hit = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // answer sequencing
   // a request is taken only in idle, so one held until its ack is
   // not taken twice
   localparam ST_IDLE = 2'b00;
   localparam ST_FETCH = 2'b01;
   localparam ST_ANSWER = 2'b10;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg take;
   reg store_pick_q;
   reg [31:0] hold_q;

   always @* begin
      state_d = state_q;
      take = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (obj_req_i) begin
               take = 1'b1;
               state_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_d = ST_ANSWER;
         end
         ST_ANSWER: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         obj_ack_o <= 1'b0;
         obj_status_o <= `DMOB_ACK_OK;
         obj_rdata_o <= 32'h00000000;
         ram_commit_o <= 1'b0;
         nv_commit_o <= 1'b0;
         store_pick_q <= 1'b0;
         hold_q <= 32'h00000000;
      end else begin
         state_q <= state_d;
         obj_ack_o <= 1'b0;
         ram_commit_o <= 1'b0;
         nv_commit_o <= 1'b0;
         if (state_q == ST_FETCH) begin
            // store read data is one cycle late; answer now
            obj_ack_o <= 1'b1;
            obj_rdata_o <= store_pick_q ? resp_rdata : hold_q;
         end
         if (take) begin
            obj_status_o <= code_d;
            store_pick_q <= 1'b0;
            hold_q <= 32'h00000000;
            // refused requests raise no commit pulse and answer with zero data
            if (code_d == `DMOB_ACK_OK) begin
               store_pick_q <= from_store && !obj_write_i;
               hold_q <= obj_write_i ? 32'h00000000 : rd_d;
               ram_commit_o <= ram_hit;
               nv_commit_o <= nv_hit;
            end
         end
      end
   end
endmodule // dmob_object_bank

// ===== sim/dmob_object_bank_monitor.sv
// checker bound to the object bank: answer timing, commits, refusals
// assumes it sees the bank ports only, one clock, async reset high
`timescale 1ns/1ps
module dmob_object_bank_monitor (
   input wire clock_i,
   input wire reset_i,
   input wire obj_req_i,
   input wire obj_write_i,
   input wire [15:0] obj_index_i,
   input wire [7:0] obj_subindex_i,
   input wire [31:0] obj_wdata_i,
   input wire obj_ack_o,
   input wire [1:0] obj_status_o,
   input wire [31:0] obj_rdata_o,
   input wire ram_commit_o,
   input wire nv_commit_o,
   input wire [3:0] display_unit_setting_i
);
   // ==========================
   // request tracking
   logic take_q;
   logic [3:0] disp_q;
   wire [15:0] ix = obj_index_i;
   // no take while an answer is pending or its ack still stands
   wire take = obj_req_i && !take_q && !obj_ack_o;
   wire wr = take && obj_write_i;
   wire rd = take && !obj_write_i;
   wire save = obj_wdata_i == 32'h65766173;
   wire mon = ix == 16'h2100 || ix == 16'h2110 || ix == 16'h2120
      || ix == 16'h2130 || ix == 16'h2200;
   // the bank judges the display setting one edge late
   wire prof_on = disp_q == 4'h2;
   always @(posedge clock_i or posedge reset_i)
      if (reset_i) begin
         take_q <= 1'b0;
         disp_q <= 4'h0;
      end else begin
         take_q <= take;
         disp_q <= display_unit_setting_i;
      end
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // ==========================
   // assertions
   property p_ack; take |-> ##2 obj_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("request not answered");
   property p_ram; wr && ix == 16'h2060 && save |=> ram_commit_o; endproperty
   a_ram: assert property (p_ram)
      else $error("ram commit pulse missing");
   property p_one; ram_commit_o |-> !nv_commit_o ##1 !ram_commit_o; endproperty
   a_one: assert property (p_one)
      else $error("ram commit not a lone pulse");
   property p_nv; wr && ix == 16'h2070 && save |=> nv_commit_o; endproperty
   a_nv: assert property (p_nv)
      else $error("nonvolatile commit pulse missing");
   property p_rd16;
      rd && mon |-> ##2 obj_status_o == 2'h0 && obj_rdata_o[31:16] == 16'h0;
   endproperty
   a_rd16: assert property (p_rd16)
      else $error("monitor read bad status or upper half");
   property p_ro;
      wr && (mon || ix == 16'h2140 || ix == 16'h2150)
         |=> !ram_commit_o && !nv_commit_o ##1 obj_status_o == 2'h1;
   endproperty
   a_ro: assert property (p_ro)
      else $error("write to read-only object not refused");
   property p_prof; take && ix[15:12] == 4'h6 && !prof_on
      |-> ##2 obj_status_o == 2'h3; endproperty
   a_prof: assert property (p_prof)
      else $error("profile object not refused");
   property p_dout; rd && ix == 16'h60FD && obj_subindex_i == 8'h01 && prof_on
      |-> ##2 (obj_rdata_o & 32'hFF78FFFF) == 32'h0; endproperty
   a_dout: assert property (p_dout)
      else $error("reserved output-status bits set");
endmodule // dmob_object_bank_monitor

bind dmob_object_bank dmob_object_bank_monitor u_mon (.*);

// ===== sim/dmob_drive_model.sv
// drive core model: returns register replies to the bank
// assumes the bench asks for a reply with a one-cycle send pulse
`timescale 1ns/1ps
module dmob_drive_model (
   input wire clock_i,
   input wire send_i,
   input wire is_write_i,
   input wire [31:0] word_i,
   output logic reply_valid_o = 1'b0,
   output logic reply_is_write_o = 1'b0,
   output logic [31:0] reply_word_o = 32'h0
);
   // word is junk outside the valid cycle, so a late sample shows up
   always @(posedge clock_i) begin
      reply_valid_o <= send_i;
      reply_is_write_o <= is_write_i;
      reply_word_o <= send_i ? word_i : ~reply_word_o;
   end
endmodule // dmob_drive_model

// ===== sim/dmob_object_bank_bench.sv
// self-checking bench for the object bank with a drive reply model
// assumes 100 MHz clock and the two-cycle answer of the bank
`timescale 1ns/1ps
module dmob_object_bank_bench;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic obj_req_i = 1'b0, obj_write_i = 1'b0, send = 1'b0, sw = 1'b0;
   logic [15:0] obj_index_i = 16'h0, st = 16'h0;
   logic [7:0] obj_subindex_i = 8'h0;
   logic [31:0] obj_wdata_i = 32'h0, sword = 32'h0, obj_rdata_o, reply_word_i;
   logic obj_ack_o, ram_commit_o, nv_commit_o, reply_valid_i, reply_is_write_i;
   logic [1:0] obj_status_o, cm;
   logic [15:0] output_frequency_i = 16'h0, output_current_i = 16'h0;
   logic [15:0] torque_reference_monitor_item_i = 16'h0;
   logic [15:0] speed_monitor_item_i = 16'h0;
   logic torque_monitor_valid_i = 1'b0, speed_monitor_valid_i = 1'b0;
   logic relay_contact_output_i = 1'b0;
   logic [3:0] display_unit_setting_i = 4'h0;
   int n_mismatch = 0;
   int check_count = 0;
   dmob_object_bank u_dut (.*, .drive_running_i(st[0]), .zero_speed_i(st[1]),
      .reverse_i(st[2]), .fault_reset_input_i(st[3]), .speed_agree_i(st[4]),
      .drive_ready_i(st[5]), .alarm_i(st[6]), .fault_i(st[7]),
      .operation_error_i(st[8]), .power_loss_i(st[9]),
      .network_command_source_i(st[10]), .fault_relay_terminals_i(st[11]),
      .optocoupler_output_one_i(st[12]), .optocoupler_output_two_i(st[13]),
      .motor2_selected_i(st[14]), .zero_servo_done_i(st[15]));
   dmob_drive_model u_drv (.clock_i(clock_i), .send_i(send), .is_write_i(sw),
      .word_i(sword), .reply_valid_o(reply_valid_i),
      .reply_is_write_o(reply_is_write_i), .reply_word_o(reply_word_i));
   always #5 clock_i = ~clock_i;
   // ==========================
   // shared tasks
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task rq(input logic w, input logic [15:0] ix, input logic [7:0] sub,
      input logic [31:0] d, input logic [1:0] s, input logic [31:0] e,
      input logic [1:0] c);
      @(posedge clock_i);
      obj_req_i <= 1'b1;
      obj_write_i <= w;
      obj_index_i <= ix;
      obj_subindex_i <= sub;
      obj_wdata_i <= d;
      // request stands until ack is sampled high; values read at an
      // edge are those launched by the edge before
      @(posedge clock_i);
      @(posedge clock_i);
      cm = {ram_commit_o, nv_commit_o};
      @(posedge clock_i);
      chk({31'h0, obj_ack_o}, 32'h1);
      chk({30'h0, obj_status_o}, {30'h0, s});
      chk({30'h0, cm}, {30'h0, c});
      if (!w && s == 2'h0)
         chk(obj_rdata_o, e);
      obj_req_i <= 1'b0;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================
   // scenarios
   task t_commit;
      rq(1, 16'h2060, 0, 32'h65766173, 0, 0, 2'b10);
      rq(1, 16'h2060, 0, 32'h65766173, 0, 0, 2'b10);
      rq(1, 16'h2070, 0, 32'h65766173, 0, 0, 2'b01);
      rq(1, 16'h2060, 0, 32'h53415645, 0, 0, 2'b00);
      $display("commit test done");
   endtask
   task t_status;
      for (int i = 0; i < 16; i++) begin
         @(posedge clock_i);
         st <= 16'h1 << i;
         rq(0, 16'h2100, 0, 0, 0, 32'h1 << i, 0);
      end
      $display("status test done");
   endtask
   task t_mon;
      @(posedge clock_i);
      output_frequency_i <= 16'h1234;
      output_current_i <= 16'h0ABC;
      torque_reference_monitor_item_i <= 16'h0F0F;
      speed_monitor_item_i <= 16'h0777;
      torque_monitor_valid_i <= 1'b1;
      rq(0, 16'h2110, 0, 0, 0, 32'h1234, 0);
      rq(0, 16'h2120, 0, 0, 0, 32'h0ABC, 0);
      rq(0, 16'h2130, 0, 0, 0, 32'h0F0F, 0);
      rq(0, 16'h2200, 0, 0, 0, 32'h0, 0);
      rq(1, 16'h2110, 0, 32'h1, 1, 0, 0);
      rq(1, 16'h2140, 1, 32'h1, 1, 0, 0);
      rq(1, 16'h2300, 0, 32'h65766173, 2, 0, 0);
      torque_monitor_valid_i <= 1'b0;
      speed_monitor_valid_i <= 1'b1;
      rq(0, 16'h2130, 0, 0, 0, 32'h0, 0);
      rq(0, 16'h2200, 0, 0, 0, 32'h0777, 0);
      $display("monitor test done");
   endtask
   task t_resp;
      @(posedge clock_i);
      send <= 1'b1;
      sword <= 32'h0021ABCD;
      @(posedge clock_i);
      send <= 1'b0;
      rq(0, 16'h2140, 1, 0, 0, 32'h0021ABCD, 0);
      rq(0, 16'h2140, 0, 0, 0, 32'h1, 0);
      send <= 1'b1;
      sw <= 1'b1;
      sword <= 32'h0102FEDC;
      @(posedge clock_i);
      send <= 1'b0;
      rq(0, 16'h2150, 1, 0, 0, 32'h0102FEDC, 0);
      $display("reply test done");
   endtask
   task t_prof;
      st <= 16'h3800;
      relay_contact_output_i <= 1'b1;
      rq(0, 16'h60FD, 1, 0, 3, 0, 0);
      display_unit_setting_i <= 4'h2;
      rq(0, 16'h60FD, 1, 0, 0, 32'h00870000, 0);
      $display("profile test done");
   endtask
   initial begin
      repeat (12) @(posedge clock_i);
      reset_i <= 1'b0;
      t_commit;
      t_status;
      t_mon;
      t_resp;
      t_prof;
      end_sim;
   end
   // the 34 requests of four or five cycles fit well inside this span
   initial begin
      #20000;
      n_mismatch++;
      end_sim;
   end
endmodule // dmob_object_bank_bench
